// ### fsp_seq.sv
/*
  flash self-programming sequencer: control register, store/load timed
  sequence, page buffer fill, erase/write/lock timing, section decode.
  assumes cpu strobes on sys_clk; rc clock and fuses arrive as pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsp_params.svh"
module fsp_seq #(
  parameter bit VARIANT16 = 1'b0,
  parameter int PROG_TICKS = `FSP_PROG_TICKS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlWData,
  input wire logic spmExec,
  input wire logic lpmExec,
  input wire logic [15:0] zPtr,
  input wire logic [7:0] r0Data,
  input wire logic [7:0] r1Data,
  input wire logic eeprom_write_busy,
  input wire logic boot_size_sel_hi,
  input wire logic boot_size_sel_lo,
  input wire logic rcClk,
  input wire logic fetchValid,
  input wire logic [12:0] fetchAddr,
  input wire logic [5:0] flashBufAddr,
  output logic [7:0] self_prog_ctrl_reg,
  output logic [12:0] bootStart,
  output logic [12:0] appEnd,
  output logic cpuStall,
  output logic flashErase,
  output logic flashWrite,
  output logic [6:0] page_select_field,
  output logic lockReadStrobe,
  output logic [7:0] lockBits,
  output logic [15:0] flashBufData
);
  localparam int WORD_W = VARIANT16 ? 6 : 5;
  localparam int PC_W = VARIANT16 ? 13 : 12;

  fsp_pkg::fsp_state_e state, next_state;
  logic [7:0] next_ctrl;
  logic [2:0] winCnt, next_winCnt;
  logic [15:0] tickCnt, next_tickCnt;
  logic targetNrww, next_targetNrww;
  logic [7:0] next_lockBits;
  logic [7:0] lockReq, next_lockReq;
  logic next_erase, next_write, next_lockRead, bufWr;
  logic rcSync1, rcSync2, rcPrev;
  logic fuseHi1, fuseHi2, fuseLo1, fuseLo2;

  fsp_buf_if #(.AW(WORD_W), .DW(16)) bufIf ();

  fsp_page_buf #(.AW(WORD_W), .DW(16)) u_buf (
    .sys_clk(sys_clk),
    .buf_port(bufIf)
  );

  wire fsp_pkg::fsp_page_t pageW = zPtr[PC_W:WORD_W+1];
  wire [WORD_W-1:0] word_in_page_field = zPtr[WORD_W:1];
  wire fsp_pkg::fsp_waddr_t pageAddr = 13'({pageW, {WORD_W{1'b0}}});

  wire fsp_pkg::fsp_waddr_t nrwwStart = VARIANT16 ? `FSP_NRWW16 : `FSP_NRWW8;
  wire pageInNrww = pageAddr >= nrwwStart;
  wire fetchInNrww = fetchAddr >= nrwwStart;

  wire [1:0] bootSel = {fuseHi2, fuseLo2};
  wire fsp_pkg::fsp_waddr_t boot8 =
    (bootSel == 2'h3) ? `FSP_BOOT8_11 :
    (bootSel == 2'h2) ? `FSP_BOOT8_10 :
    (bootSel == 2'h1) ? `FSP_BOOT8_01 : `FSP_BOOT8_00;
  wire fsp_pkg::fsp_waddr_t boot16 =
    (bootSel == 2'h3) ? `FSP_BOOT16_11 :
    (bootSel == 2'h2) ? `FSP_BOOT16_10 :
    (bootSel == 2'h1) ? `FSP_BOOT16_01 : `FSP_BOOT16_00;
  wire fsp_pkg::fsp_waddr_t bootW = VARIANT16 ? boot16 : boot8;

  wire rcTick = rcSync2 & ~rcPrev;
  wire lastTick = tickCnt == 16'(PROG_TICKS - 1);

  wire self_prog_enable = self_prog_ctrl_reg[`FSP_BIT_EN];
  wire page_erase_cmd = self_prog_ctrl_reg[`FSP_BIT_ERASE];
  wire page_write_cmd = self_prog_ctrl_reg[`FSP_BIT_WRITE];
  wire lock_bits_access = self_prog_ctrl_reg[`FSP_BIT_LOCK];
  wire rww_reenable_cmd = self_prog_ctrl_reg[`FSP_BIT_REEN];
  wire rww_busy_flag = self_prog_ctrl_reg[`FSP_BIT_RWWB];
  wire [7:0] ctrlIdle = self_prog_ctrl_reg & `FSP_CTRL_RWWB_MASK;
  // no control writes while eeprom busy
  wire ctrlAccept = ctrlWrite & ~eeprom_write_busy;
  wire [7:0] lockNew = (lockReq & ~`FSP_LOCK_KEEP_MASK) | `FSP_LOCK_KEEP_MASK;

  wire opFlash = (state == fsp_pkg::FSP_BUSY) &
    (page_erase_cmd | page_write_cmd);
  wire next_stall = fetchValid & opFlash & (targetNrww | ~fetchInNrww);

  assign bufIf.wrEn = bufWr;
  assign bufIf.wrAddr = word_in_page_field;
  assign bufIf.wrData = {r1Data, r0Data};
  assign bufIf.rdAddr = flashBufAddr[WORD_W-1:0];

  always_comb begin
    next_state = state;
    next_ctrl = self_prog_ctrl_reg;
    next_winCnt = winCnt;
    next_tickCnt = tickCnt;
    next_targetNrww = targetNrww;
    next_lockBits = lockBits;
    next_lockReq = lockReq;
    next_erase = 1'b0;
    next_write = 1'b0;
    next_lockRead = 1'b0;
    bufWr = 1'b0;
    case (state)
      fsp_pkg::FSP_IDLE: begin
        if (ctrlAccept) begin
          next_ctrl = (ctrlWData & `FSP_CTRL_CMD_MASK) | ctrlIdle;
          next_winCnt = 3'h0;
          if (ctrlWData[`FSP_BIT_EN]) begin
            next_state = fsp_pkg::FSP_ARMED;
          end
        end
      end
      fsp_pkg::FSP_ARMED: begin
        next_winCnt = winCnt + 3'h1;
        if (spmExec) begin
          next_tickCnt = 16'h0000;
          next_targetNrww = pageInNrww;
          if (page_erase_cmd | page_write_cmd) begin
            next_erase = page_erase_cmd;
            next_write = page_write_cmd;
            next_state = fsp_pkg::FSP_BUSY;
            if (!pageInNrww) begin
              next_ctrl[`FSP_BIT_RWWB] = 1'b1;
            end
          end else if (lock_bits_access) begin
            // lock data captured at the store
            next_lockReq = r0Data;
            next_state = fsp_pkg::FSP_BUSY;
          end else if (rww_reenable_cmd) begin
            next_ctrl = 8'h00;
            next_state = fsp_pkg::FSP_IDLE;
          end else begin
            bufWr = 1'b1;
            next_ctrl = ctrlIdle;
            next_state = fsp_pkg::FSP_IDLE;
          end
        end else if (lpmExec && lock_bits_access &&
                     winCnt < 3'(`FSP_LPM_WIN)) begin
          next_lockRead = 1'b1;
          next_ctrl = ctrlIdle;
          next_state = fsp_pkg::FSP_IDLE;
        end else if (winCnt == 3'(`FSP_SPM_WIN - 1)) begin
          next_ctrl = ctrlIdle;
          next_state = fsp_pkg::FSP_IDLE;
        end
      end
      fsp_pkg::FSP_BUSY: begin
        if (rcTick) begin
          next_tickCnt = tickCnt + 16'h0001;
          if (lastTick) begin
            next_ctrl = ctrlIdle;
            next_state = fsp_pkg::FSP_IDLE;
            if (lock_bits_access) begin
              next_lockBits = lockBits & lockNew;
            end
          end
        end
      end
      default: begin
        next_state = fsp_pkg::FSP_IDLE;
        next_ctrl = `FSP_CTRL_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rcSync1 <= 1'b0;
      rcSync2 <= 1'b0;
      rcPrev <= 1'b0;
      fuseHi1 <= 1'b0;
      fuseHi2 <= 1'b0;
      fuseLo1 <= 1'b0;
      fuseLo2 <= 1'b0;
    end else begin
      rcSync1 <= rcClk;
      rcSync2 <= rcSync1;
      rcPrev <= rcSync2;
      fuseHi1 <= boot_size_sel_hi;
      fuseHi2 <= fuseHi1;
      fuseLo1 <= boot_size_sel_lo;
      fuseLo2 <= fuseLo1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= fsp_pkg::FSP_IDLE;
      self_prog_ctrl_reg <= `FSP_CTRL_RST;
      winCnt <= 3'h0;
      tickCnt <= 16'h0000;
      targetNrww <= 1'b0;
      lockBits <= `FSP_LOCK_RST;
      lockReq <= `FSP_LOCK_RST;
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
      lockReadStrobe <= 1'b0;
      page_select_field <= 7'h00;
      cpuStall <= 1'b0;
      bootStart <= 13'h0000;
      appEnd <= 13'h0000;
    end else begin
      state <= next_state;
      self_prog_ctrl_reg <= next_ctrl;
      winCnt <= next_winCnt;
      tickCnt <= next_tickCnt;
      targetNrww <= next_targetNrww;
      lockBits <= next_lockBits;
      lockReq <= next_lockReq;
      flashErase <= next_erase;
      flashWrite <= next_write;
      lockReadStrobe <= next_lockRead;
      if (next_erase | next_write) begin
        page_select_field <= pageW;
      end
      cpuStall <= next_stall;
      bootStart <= bootW;
      appEnd <= bootW - 13'h0001;
    end
  end

  assign flashBufData = bufIf.rdData;
endmodule : fsp_seq
`default_nettype wire

// ### fsp_params.svh
/*
  constants for the flash self-programming sequencer: control bit positions,
  reset values, window lengths, write timing and section boundaries.
  assumes inclusion by bare name from the sequencer sources.
*/
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// control register bit positions, reset values and masks
`define FSP_BIT_EN 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REEN 4
`define FSP_BIT_RWWB 6
`define FSP_CTRL_RST 8'h00
`define FSP_CTRL_CMD_MASK 8'h1F
`define FSP_CTRL_RWWB_MASK 8'h40
`define FSP_LOCK_RST 8'hFF
`define FSP_LOCK_KEEP_MASK 8'hC3

// cycles allowed after a control write
`define FSP_SPM_WIN 4
`define FSP_LPM_WIN 3

// write timing in microseconds and rc clock rate
`define FSP_PROG_MIN_US 3700
`define FSP_PROG_MAX_US 4500
`define FSP_RC_KHZ 8000
`define FSP_PROG_TICKS ((`FSP_PROG_MIN_US * `FSP_RC_KHZ + 999) / 1000)

// boot section starts, small variant
`define FSP_BOOT8_11 13'h0F80
`define FSP_BOOT8_10 13'h0F00
`define FSP_BOOT8_01 13'h0E00
`define FSP_BOOT8_00 13'h0C00
// boot section starts, large variant
`define FSP_BOOT16_11 13'h1F80
`define FSP_BOOT16_10 13'h1F00
`define FSP_BOOT16_01 13'h1E00
`define FSP_BOOT16_00 13'h1C00
// first word of the halted-read section
`define FSP_NRWW8 13'h0C00
`define FSP_NRWW16 13'h1C00

`endif

// ### fsp_pkg.sv
/*
  types for the flash self-programming sequencer.
  assumes nothing beyond a systemverilog compiler.
*/
package fsp_pkg;
  typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_e;
  typedef logic [6:0] fsp_page_t;
  typedef logic [12:0] fsp_waddr_t;
endpackage : fsp_pkg

// ### fsp_buf_if.sv
/*
  signals between the sequencer and its temporary page buffer.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsp_buf_if #(parameter int AW = 5, parameter int DW = 16);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr,
    output rdData);
  modport ctl (output wrEn, output wrAddr, output wrData, output rdAddr,
    input rdData);
endinterface : fsp_buf_if
`default_nettype wire

// ### fsp_page_buf.sv
/*
  temporary page buffer: one write port, one registered read port.
  assumes the sequencer drives the write side on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buf #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  fsp_buf_if.mem buf_port
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (buf_port.wrEn) begin
      mem[buf_port.wrAddr] <= buf_port.wrData;
    end
    buf_port.rdData <= mem[buf_port.rdAddr];
  end
endmodule : fsp_page_buf
`default_nettype wire

// ### fsp_seq_asserts.sv
/*
  port-level assertions for the self-programming sequencer.
  assumes it is bound to fsp_seq, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_seq_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ctrlWrite,
  input wire logic spmExec,
  input wire logic lpmExec,
  input wire logic eeprom_write_busy,
  input wire logic fetchValid,
  input wire logic [7:0] self_prog_ctrl_reg,
  input wire logic [12:0] bootStart,
  input wire logic [12:0] appEnd,
  input wire logic cpuStall,
  input wire logic flashErase,
  input wire logic flashWrite,
  input wire logic lockReadStrobe
);
  logic [1:0] upCnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  app_end_a: assert property (
    upCnt == 2'h3 |-> appEnd == bootStart - 13'h1)
    else $error("application end not one below boot start");
  erase_cause_a: assert property (
    flashErase |-> $past(spmExec) && $past(self_prog_ctrl_reg[1]))
    else $error("erase pulse without store");
  write_cause_a: assert property (
    flashWrite |-> $past(spmExec) && $past(self_prog_ctrl_reg[2]))
    else $error("write pulse without store");
  enable_hold_a: assert property (
    flashErase |=> self_prog_ctrl_reg[0] [*8])
    else $error("enable dropped during operation");
  lock_read_a: assert property (
    lockReadStrobe |-> $past(lpmExec) && !self_prog_ctrl_reg[0])
    else $error("lock read strobe wrong");
  win_expire_a: assert property (
    $rose(self_prog_ctrl_reg[0]) ##0 (!spmExec && !lpmExec) [*4] |-> ##2
    !self_prog_ctrl_reg[0])
    else $error("armed state outlived its window");
  ee_refuse_a: assert property (
    ctrlWrite && eeprom_write_busy && !self_prog_ctrl_reg[0] |=>
    !self_prog_ctrl_reg[0])
    else $error("control write taken while eeprom busy");
  busy_clear_a: assert property (
    $fell(self_prog_ctrl_reg[6]) |-> $past(spmExec) &&
    $past(self_prog_ctrl_reg[4]))
    else $error("busy flag cleared without re-enable");
  stall_cause_a: assert property (
    cpuStall |-> $past(fetchValid))
    else $error("stall without fetch");
  cover property (flashErase);
  cover property (flashWrite);
  cover property (lockReadStrobe);
endmodule : fsp_seq_asserts
`default_nettype wire

// ### fsp_cpu_model.sv
/*
  cpu core model running the self-programming timed sequence.
  assumes sys_clk and the sequencer control readback.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
  input wire logic sys_clk,
  input wire logic [7:0] self_prog_ctrl_reg,
  input wire logic eeprom_write_busy,
  output logic ctrlWrite,
  output logic [7:0] ctrlWData,
  output logic spmExec,
  output logic lpmExec,
  output logic [15:0] zPtr,
  output logic [7:0] r0Data,
  output logic [7:0] r1Data
);
  initial begin
    {ctrlWrite, ctrlWData, spmExec, lpmExec, zPtr, r0Data, r1Data} = '0;
  end
  // control write, then store or load after gap cycles
  task automatic cmd(input logic [7:0] c, input logic [15:0] z,
    input logic [15:0] d, input int gap, input bit lpm, input bit rude);
    int n;
    n = 0;
    while (!rude && n < 9000 && (self_prog_ctrl_reg[0] !== 1'b0 ||
      eeprom_write_busy !== 1'b0)) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    ctrlWrite = 1'b1;
    ctrlWData = c;
    // pointer byte bit and word field
    zPtr = c[2] ? {z[15:6], 6'h00} : {z[15:1], 1'b0};
    {r1Data, r0Data} = d;
    @(posedge sys_clk);
    #1;
    ctrlWrite = 1'b0;
    ctrlWData = ~c;
    repeat (gap) begin
      @(posedge sys_clk);
      #1;
    end
    if (lpm) lpmExec = 1'b1;
    else spmExec = 1'b1;
    @(posedge sys_clk);
    #1;
    spmExec = 1'b0;
    lpmExec = 1'b0;
    zPtr = ~zPtr;
    {r1Data, r0Data} = ~d;
  endtask : cmd
endmodule : fsp_cpu_model
`default_nettype wire

// ### tb_top.sv
/*
  self-checking bench for the sequencer, small and large variants.
  assumes fsp_seq, fsp_cpu_model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsp_params.svh"
module tb_top;
  localparam int PT = 8;
  logic sys_clk, nrst, rcClk, eeprom_write_busy, fetchValid;
  logic boot_size_sel_hi, boot_size_sel_lo, ctrlWrite, spmExec, lpmExec;
  logic cpuStall, flashErase, flashWrite, lockReadStrobe;
  logic [7:0] ctrlWData, r0Data, r1Data, self_prog_ctrl_reg, lockBits;
  logic [15:0] zPtr, flashBufData;
  logic [12:0] fetchAddr, bootStart, appEnd;
  logic [6:0] page_select_field;
  logic [5:0] flashBufAddr;
  logic [7:0] ctrlL;
  logic [12:0] bootStartL;
  logic [6:0] pageL;
  int fails, comparisons;
  fsp_seq #(.PROG_TICKS(PT)) dut (.*);
  fsp_seq #(.VARIANT16(1'b1), .PROG_TICKS(PT)) dut16 (.*,
    .self_prog_ctrl_reg(ctrlL), .bootStart(bootStartL), .appEnd(),
    .cpuStall(), .flashErase(), .flashWrite(), .page_select_field(pageL),
    .lockReadStrobe(), .lockBits(), .flashBufData());
  fsp_cpu_model cpu (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rcClk = 1'b0;
    #3;
    forever #50 rcClk = ~rcClk;
  end
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic probe(input logic [12:0] a, input logic e);
    fetchValid = 1'b1;
    fetchAddr = a;
    step;
    fetchValid = 1'b0;
    chk("stall", {15'h0, e}, {15'h0, cpuStall});
  endtask : probe
  task automatic wait_done(output int n);
    n = 0;
    while (self_prog_ctrl_reg[0] !== 1'b0 && n < 5000) begin
      step;
      n++;
    end
  endtask : wait_done
  task automatic t_boot;
    logic [12:0] st[4];
    logic [12:0] sl[4];
    st = '{`FSP_BOOT8_00, `FSP_BOOT8_01, `FSP_BOOT8_10, `FSP_BOOT8_11};
    sl = '{`FSP_BOOT16_00, `FSP_BOOT16_01, `FSP_BOOT16_10, `FSP_BOOT16_11};
    for (int i = 0; i < 4; i++) begin
      {boot_size_sel_hi, boot_size_sel_lo} = 2'(i);
      repeat (4) step;
      chk("boot start", {3'h0, st[i]}, {3'h0, bootStart});
      chk("app end", {3'h0, st[i] - 13'h1}, {3'h0, appEnd});
      chk("boot large", {3'h0, sl[i]}, {3'h0, bootStartL});
    end
  endtask : t_boot
  task automatic t_erase;
    int n;
    cpu.cmd(8'h03, 16'hE140, 16'h0000, 0, 1'b0, 1'b0);
    chk("erase", 16'h1, {15'h0, flashErase});
    chk("page", 16'h5, {9'h0, page_select_field});
    chk("ctrl busy", 16'h43, {8'h0, self_prog_ctrl_reg});
    probe(13'h0100, 1'b1);
    probe(13'h0C00, 1'b0);
    wait_done(n);
    chk("length", 16'h1, {15'h0, n > PT * 12 - 18 && n < PT * 13 + 6});
    chk("ctrl done", 16'h40, {8'h0, self_prog_ctrl_reg});
    cpu.cmd(8'h11, 16'h0000, 16'h0000, 1, 1'b0, 1'b0);
    chk("reenable", 16'h0, {8'h0, self_prog_ctrl_reg});
  endtask : t_erase
  task automatic t_fill;
    cpu.cmd(8'h01, 16'h000E, 16'hA55A, 3, 1'b0, 1'b0);
    cpu.cmd(8'h01, 16'h0010, 16'h0F0F, 0, 1'b0, 1'b0);
    cpu.cmd(8'h01, 16'h0010, 16'h1234, 4, 1'b0, 1'b0);
    flashBufAddr = 6'h07;
    step;
    chk("word 7", 16'hA55A, flashBufData);
    flashBufAddr = 6'h08;
    step;
    chk("word 8", 16'h0F0F, flashBufData);
  endtask : t_fill
  task automatic t_write;
    int n;
    cpu.cmd(8'h05, 16'h1900, 16'h0000, 1, 1'b0, 1'b0);
    chk("write", 16'h1, {15'h0, flashWrite});
    chk("page", 16'h64, {9'h0, page_select_field});
    chk("no busy", 16'h05, {8'h0, self_prog_ctrl_reg});
    chk("large busy", 16'h45, {8'h0, ctrlL});
    chk("large page", 16'h32, {9'h0, pageL});
    probe(13'h0C00, 1'b1);
    wait_done(n);
    chk("end", 16'h0, {8'h0, self_prog_ctrl_reg});
  endtask : t_write
  task automatic t_lock;
    int n;
    cpu.cmd(8'h09, 16'h0001, 16'h0000, 2, 1'b1, 1'b0);
    chk("strobe", 16'h1, {15'h0, lockReadStrobe});
    chk("lock", 16'hFF, {8'h0, lockBits});
    chk("ctrl", 16'h0, {8'h0, self_prog_ctrl_reg});
    cpu.cmd(8'h09, 16'h0001, 16'h00C3, 1, 1'b0, 1'b0);
    wait_done(n);
    chk("lock set", 16'hC3, {8'h0, lockBits});
    eeprom_write_busy = 1'b1;
    cpu.cmd(8'h03, 16'h0040, 16'h0000, 0, 1'b0, 1'b1);
    chk("ee refuse", 16'h0, {7'h0, flashErase, self_prog_ctrl_reg});
    eeprom_write_busy = 1'b0;
  endtask : t_lock
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    fails++;
    test_done;
  end
  initial begin
    {nrst, eeprom_write_busy, fetchValid, fetchAddr, flashBufAddr} = '0;
    {boot_size_sel_hi, boot_size_sel_lo} = 2'h3;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    t_boot;
    t_erase;
    t_fill;
    t_write;
    t_lock;
    test_done;
  end
endmodule : tb_top
bind fsp_seq fsp_seq_asserts chk_i (.*);
`default_nettype wire
